// ---- shared/dmc_map.vh ----
// Register map, field positions, reset values and sequence counts
// for the dual-mode converter control block.
// Assumes inclusion by bare name from a design file.
`ifndef DMC_MAP_VH
`define DMC_MAP_VH

// ----------------------------------------
// Register byte offsets on the APB bus
// ----------------------------------------
`define DMC_OFF_CTRL 8'h00
`define DMC_OFF_INPUT 8'h04
`define DMC_OFF_RES_LO 8'h08
`define DMC_OFF_RES_HI 8'h0C
`define DMC_CTRL_RST 8'h00
`define DMC_INPUT_RST 8'h00
`define DMC_DATA_RST 8'h00
`define DMC_RDATA_ZERO 32'h00000000

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define DMC_B_DONE 7
`define DMC_B_START 6
`define DMC_B_DAC 5
`define DMC_B_EN 4
`define DMC_B_LEFT_ALIGN_SELECT 3
`define DMC_F_CLK 2:0

// ----------------------------------------
// Input control register fields
// ----------------------------------------
`define DMC_B_CONNECT 7
`define DMC_F_TRIG 5:4
`define DMC_B_DIFFERENTIAL_SELECT 3
`define DMC_F_CHAN 2:0
`define DMC_F_PAIR 1:0

// ----------------------------------------
// Sequence counts, in converter clock cycles
// ----------------------------------------
`define DMC_CNT_IDLE 4'h0
`define DMC_CNT_ONE 4'h1
`define DMC_ADC_CYCLES 4'hD
`define DMC_DAC_CYCLES 4'hB
`define DMC_SAMPLE_CYC 4'h3
`define DMC_DAC_BUILD 4'h2
`define DMC_DAC_RELEASE 4'h7
`define DMC_SAR_MSB 10'h200
`define DMC_SAR_ZERO 10'h000
`define DMC_PAD_W 6
`define DMC_LO_PAD 6'h00

// ----------------------------------------
// Clock figures in MHz; internal source divide rounds up
// ----------------------------------------
`define DMC_CORE_MHZ 250
`define DMC_INT_MHZ 2
`define DMC_INT_DIV (((`DMC_CORE_MHZ) + (`DMC_INT_MHZ) - 1) / (`DMC_INT_MHZ))
`define DMC_CLK_INTERNAL 3'h0
`define DMC_TRIG_SW 2'h0

`endif

// ---- hdl/dmc_ctrl.v ----
// Control logic of a 10-bit dual-mode (ADC or DAC) successive
// approximation converter, with an APB register slave.
// Assumes an analog front end that follows the mux, sample and
// trial-code outputs and returns one comparator level.
`timescale 1ns/1ps
`include "dmc_map.vh"

module dmc_ctrl (
  // Clock and reset
  input wire CORE_CLK,
  input wire RST_N,
  // APB slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  // Timer overflow pulses, same clock
  input wire [2:0] TMR_OVF,
  // Analog front end
  input wire COMP_HI,
  output reg POWER_EN,
  output reg OSC_FORCE_ON,
  output reg MUX_CONNECT,
  output reg MUX_DIFFERENTIAL_SELECT,
  output reg [2:0] MUX_POS_SEL,
  output reg [2:0] MUX_NEG_SEL,
  output reg SAMPLE_TRACK,
  output reg [9:0] SAR_CODE,
  // DAC output side
  output reg DAC_PINS_INPUT_ONLY,
  output reg [9:0] DAC_CODE,
  output reg DAC_BUILD,
  output reg DAC_RELEASE,
  // Status
  output reg BUSY,
  output reg DONE_FLAG
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------

  // Internal source divide; the prescaler only counts seven bits
  localparam integer int_div_full = `DMC_INT_DIV - 1;
  localparam [6:0] int_last = int_div_full[6:0];

  // One SAR decision: drop the trial bit if the input is below it
  function [9:0] sar_keep(input [9:0] trial, input [9:0] mask, input comp);
    sar_keep = comp ? trial : (trial & ~mask);
  endfunction

  // Unpack the stored byte pair into a ten-bit code
  function [9:0] unpack(input [7:0] hi, input [7:0] lo, input left_align_select);
    unpack = left_align_select ? {hi, lo[7:6]} : {hi[1:0], lo};
  endfunction

  // Converter clock tick from the shared 7-bit prescaler
  function conv_tick(input [6:0] pre, input [2:0] sel);
    reg [6:0] m;
    begin
      m = 7'h7F >> (3'h7 - sel);
      conv_tick = (sel == `DMC_CLK_INTERNAL) ? (pre == int_last) : ((pre & m) == m);
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg done_q, dac_q, en_q, left_align_select_q, connect_q, differential_select_q, mode_dac_q, comp_meta_q, comp_sync_q;
  reg [1:0] trig_q;
  reg [2:0] clk_sel_q, chan_q;
  reg [3:0] cnt_q;
  reg [6:0] pre_q;
  reg [7:0] data_hi_q, data_lo_q;
  reg [9:0] trial_q, mask_q, dac_buf_q;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire acc = PSEL & PENABLE & PREADY;
  wire hit_ctrl = (PADDR == `DMC_OFF_CTRL);
  wire hit_input = (PADDR == `DMC_OFF_INPUT);
  wire hit_lo = (PADDR == `DMC_OFF_RES_LO);
  wire hit_hi = (PADDR == `DMC_OFF_RES_HI);
  wire mapped = hit_ctrl | hit_input | hit_lo | hit_hi;
  wire wr_ctrl = acc & PWRITE & hit_ctrl;
  wire wr_input = acc & PWRITE & hit_input;
  wire wr_data = acc & PWRITE & dac_q;

  // ----------------------------------------
  // Sequencing terms
  // ----------------------------------------
  wire busy = (cnt_q != `DMC_CNT_IDLE);
  wire tick = conv_tick(pre_q, clk_sel_q);
  wire [3:0] last = mode_dac_q ? `DMC_DAC_CYCLES : `DMC_ADC_CYCLES;
  wire finish = busy & tick & (cnt_q == last);
  wire sw_start = wr_ctrl & PWDATA[`DMC_B_START] & PWDATA[`DMC_B_EN];
  wire dac_now = wr_ctrl ? PWDATA[`DMC_B_DAC] : dac_q;
  wire left_align_select_now = wr_ctrl ? PWDATA[`DMC_B_LEFT_ALIGN_SELECT] : left_align_select_q;
  wire [3:0] ovf_ext = {TMR_OVF, 1'b0};
  wire hw_start = en_q & (trig_q != `DMC_TRIG_SW) & ovf_ext[trig_q];
  wire start = (sw_start | hw_start) & ~busy;
  wire [9:0] sar_fin = sar_keep(trial_q, mask_q, comp_sync_q);
  wire [9:0] res = {~sar_fin[9], sar_fin[8:0]};
  wire [7:0] res_hi = left_align_select_q ? res[9:2] : {{`DMC_PAD_W{res[9]}}, res[9:8]};
  wire [7:0] res_lo = left_align_select_q ? {res[1:0], `DMC_LO_PAD} : res[7:0];

  // ----------------------------------------
  // Comparator synchroniser
  // ----------------------------------------
  // The level comes from analog logic outside the clock domain
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      comp_meta_q <= 1'b0;
      comp_sync_q <= 1'b0;
    end else begin
      comp_meta_q <= COMP_HI;
      comp_sync_q <= comp_meta_q;
    end
  end

  // ----------------------------------------
  // APB answer
  // ----------------------------------------
  // One wait state keeps every bus output on a flip-flop
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= `DMC_RDATA_ZERO;
    end else begin
      PREADY <= PSEL & PENABLE & ~PREADY;
      PSLVERR <= PSEL & PENABLE & ~PREADY & ~mapped;
      PRDATA <= `DMC_RDATA_ZERO;
      if (PSEL & PENABLE & ~PREADY & ~PWRITE) begin
        if (hit_ctrl) begin
          PRDATA[7:0] <= {done_q, busy, dac_q, en_q, left_align_select_q, clk_sel_q};
        end else if (hit_input) begin
          PRDATA[7:0] <= {connect_q, 1'b0, trig_q, differential_select_q, chan_q};
        end else if (hit_lo & ~dac_q) begin
          PRDATA[7:0] <= data_lo_q;
        end else if (hit_hi & ~dac_q) begin
          PRDATA[7:0] <= data_hi_q;
        end
      end
    end
  end

  // ----------------------------------------
  // Control and input registers
  // ----------------------------------------
  // A completion in the same cycle as a clear keeps the flag set
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      done_q <= 1'b0;
      dac_q <= 1'b0;
      en_q <= 1'b0;
      left_align_select_q <= 1'b0;
      clk_sel_q <= `DMC_CLK_INTERNAL;
      connect_q <= 1'b0;
      trig_q <= `DMC_TRIG_SW;
      differential_select_q <= 1'b0;
      chan_q <= 3'h0;
    end else begin
      if (wr_ctrl) begin
        dac_q <= PWDATA[`DMC_B_DAC];
        en_q <= PWDATA[`DMC_B_EN];
        left_align_select_q <= PWDATA[`DMC_B_LEFT_ALIGN_SELECT];
        clk_sel_q <= PWDATA[`DMC_F_CLK];
      end
      if (finish) begin
        done_q <= 1'b1;
      end else if (wr_ctrl & PWDATA[`DMC_B_DONE]) begin
        done_q <= 1'b0;
      end
      // Software sequences connect and channel itself
      if (wr_input) begin
        connect_q <= PWDATA[`DMC_B_CONNECT];
        trig_q <= PWDATA[`DMC_F_TRIG];
        differential_select_q <= PWDATA[`DMC_B_DIFFERENTIAL_SELECT];
        chan_q <= PWDATA[`DMC_F_CHAN];
      end
    end
  end

  // ----------------------------------------
  // Data byte pair
  // ----------------------------------------
  // ADC mode: only a completion writes it; DAC mode: only software
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      data_hi_q <= `DMC_DATA_RST;
      data_lo_q <= `DMC_DATA_RST;
    end else begin
      if (finish & ~mode_dac_q) begin
        data_hi_q <= res_hi;
        data_lo_q <= res_lo;
      end else begin
        if (wr_data & hit_hi) begin
          data_hi_q <= PWDATA[7:0];
        end
        if (wr_data & hit_lo) begin
          data_lo_q <= PWDATA[7:0];
        end
      end
    end
  end

  // ----------------------------------------
  // Converter clock prescaler
  // ----------------------------------------
  // Restarted at each start so the first cycle is a whole one
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pre_q <= 7'h00;
    end else if (start) begin
      pre_q <= 7'h00;
    end else if ((clk_sel_q == `DMC_CLK_INTERNAL) & (pre_q == int_last)) begin
      pre_q <= 7'h00;
    end else begin
      pre_q <= pre_q + 7'h01;
    end
  end

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  // Cycle counter, zero when idle; a start reads the bits written with it
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_q <= `DMC_CNT_IDLE;
      mode_dac_q <= 1'b0;
      dac_buf_q <= `DMC_SAR_ZERO;
    end else if (start) begin
      cnt_q <= `DMC_CNT_ONE;
      mode_dac_q <= dac_now;
      if (dac_now) begin
        dac_buf_q <= unpack(data_hi_q, data_lo_q, left_align_select_now);
      end
    end else if (~en_q) begin
      cnt_q <= `DMC_CNT_IDLE;
    end else if (finish) begin
      cnt_q <= `DMC_CNT_IDLE;
    end else if (busy & tick) begin
      cnt_q <= cnt_q + `DMC_CNT_ONE;
    end
  end

  // ----------------------------------------
  // SAR trial register
  // ----------------------------------------
  // Trials run in offset binary; the sign flip happens at store
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      trial_q <= `DMC_SAR_ZERO;
      mask_q <= `DMC_SAR_ZERO;
    end else if (busy & tick & ~mode_dac_q) begin
      if (cnt_q == `DMC_SAMPLE_CYC) begin
        trial_q <= `DMC_SAR_MSB;
        mask_q <= `DMC_SAR_MSB;
      end else if (cnt_q > `DMC_SAMPLE_CYC) begin
        trial_q <= sar_fin | (mask_q >> 1);
        mask_q <= mask_q >> 1;
      end
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  // Enabled DAC mode parks the input mux whatever its settings say
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      POWER_EN <= 1'b0;
      OSC_FORCE_ON <= 1'b0;
      MUX_CONNECT <= 1'b0;
      MUX_DIFFERENTIAL_SELECT <= 1'b0;
      MUX_POS_SEL <= 3'h0;
      MUX_NEG_SEL <= 3'h0;
      SAMPLE_TRACK <= 1'b0;
      SAR_CODE <= `DMC_SAR_ZERO;
      DAC_PINS_INPUT_ONLY <= 1'b0;
      DAC_CODE <= `DMC_SAR_ZERO;
      DAC_BUILD <= 1'b0;
      DAC_RELEASE <= 1'b0;
      BUSY <= 1'b0;
      DONE_FLAG <= 1'b0;
    end else begin
      POWER_EN <= en_q;
      OSC_FORCE_ON <= en_q & (clk_sel_q == `DMC_CLK_INTERNAL);
      MUX_CONNECT <= connect_q & ~(en_q & dac_q);
      MUX_DIFFERENTIAL_SELECT <= differential_select_q & ~(en_q & dac_q);
      // Pair n uses pins 2n and 2n+1
      if (differential_select_q) begin
        MUX_POS_SEL <= {chan_q[`DMC_F_PAIR], 1'b0};
        MUX_NEG_SEL <= {chan_q[`DMC_F_PAIR], 1'b1};
      end else begin
        MUX_POS_SEL <= chan_q;
        MUX_NEG_SEL <= 3'h0;
      end
      SAMPLE_TRACK <= ~mode_dac_q & (cnt_q == `DMC_SAMPLE_CYC);
      SAR_CODE <= trial_q;
      DAC_PINS_INPUT_ONLY <= en_q & dac_q;
      DAC_CODE <= dac_buf_q;
      DAC_BUILD <= mode_dac_q & (cnt_q >= `DMC_DAC_BUILD);
      DAC_RELEASE <= mode_dac_q & (cnt_q >= `DMC_DAC_RELEASE);
      BUSY <= busy;
      DONE_FLAG <= done_q;
    end
  end

endmodule // dmc_ctrl

// ---- bench/dmc_ctrl_asserts.sv ----
// Port-level checks for the converter control block.
// Assumes binding onto dmc_ctrl, single core clock.
`timescale 1ns/1ps
module dmc_ctrl_asserts (
  // Clock, reset, bus
  input logic CORE_CLK,
  input logic RST_N,
  input logic PSEL,
  input logic PENABLE,
  input logic PREADY,
  // Converter side
  input logic POWER_EN,
  input logic MUX_CONNECT,
  input logic MUX_DIFFERENTIAL_SELECT,
  input logic [2:0] MUX_POS_SEL,
  input logic [2:0] MUX_NEG_SEL,
  input logic SAMPLE_TRACK,
  input logic DAC_PINS_INPUT_ONLY,
  input logic [9:0] DAC_CODE,
  input logic DAC_BUILD,
  input logic DAC_RELEASE,
  input logic BUSY,
  input logic DONE_FLAG
);
  // --------------------
  // Properties
  // --------------------
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);
  // Bus access: setup, one waiting cycle, then the answer
  sequence s_setup;
    PSEL && !PENABLE ##1 PSEL && PENABLE;
  endsequence
  sequence s_answer;
    !PREADY ##1 PREADY;
  endsequence
  a_bus_answer: assert property (s_setup |-> s_answer)
    else $error("bus answer late or early");
  a_dac_pins_forced: assert property (DAC_PINS_INPUT_ONLY |-> !MUX_CONNECT && !MUX_DIFFERENTIAL_SELECT && POWER_EN)
    else $error("mux live in dac mode");
  a_single_half_ref: assert property (MUX_CONNECT && !MUX_DIFFERENTIAL_SELECT |-> MUX_NEG_SEL == 3'h0)
    else $error("single-ended reference wrong");
  a_pair_route: assert property (MUX_DIFFERENTIAL_SELECT |-> !MUX_POS_SEL[0] && MUX_NEG_SEL == MUX_POS_SEL + 3'h1)
    else $error("pair routing wrong");
  a_sample_in_busy: assert property (SAMPLE_TRACK |-> BUSY && !DAC_BUILD)
    else $error("sample outside adc conversion");
  a_done_on_finish: assert property ($fell(BUSY) && POWER_EN |-> DONE_FLAG)
    else $error("finish without done");
  a_done_after_busy: assert property ($rose(DONE_FLAG) |-> $past(BUSY))
    else $error("done without conversion");
  a_release_in_build: assert property (DAC_RELEASE |-> DAC_BUILD)
    else $error("release outside build");
  a_dac_held: assert property (DAC_BUILD && $past(DAC_BUILD) |-> $stable(DAC_CODE))
    else $error("dac code moved");
endmodule // dmc_ctrl_asserts

bind dmc_ctrl dmc_ctrl_asserts dmc_ctrl_asserts_inst (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .POWER_EN(POWER_EN),
  .MUX_CONNECT(MUX_CONNECT), .MUX_DIFFERENTIAL_SELECT(MUX_DIFFERENTIAL_SELECT), .MUX_POS_SEL(MUX_POS_SEL), .MUX_NEG_SEL(MUX_NEG_SEL),
  .SAMPLE_TRACK(SAMPLE_TRACK), .DAC_PINS_INPUT_ONLY(DAC_PINS_INPUT_ONLY), .DAC_CODE(DAC_CODE),
  .DAC_BUILD(DAC_BUILD), .DAC_RELEASE(DAC_RELEASE), .BUSY(BUSY), .DONE_FLAG(DONE_FLAG));

// ---- bench/dmc_front_model.sv ----
// Behavioural analog front end: input mux, sample-and-hold, comparator.
// Assumes offset-binary pin levels, 10'h200 meaning half supply.
`timescale 1ns/1ps
module dmc_front_model (
  // Clock and reset
  input logic clk,
  input logic rst_n,
  // Controls from the block
  input logic pwr,
  input logic conn,
  input logic differential_select,
  input logic [2:0] pos_sel,
  input logic [2:0] neg_sel,
  input logic track,
  input logic [9:0] trial,
  // Pin levels and comparator
  input logic [79:0] lvl,
  output logic comp
);
  logic [9:0] held_q;
  logic tog_q;
  // --------------------
  // Sample and compare
  // --------------------
  // Held value freezes outside the track window; an open mux drifts
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held_q <= 10'h155;
      tog_q <= 1'b0;
    end else begin
      tog_q <= ~tog_q;
      if (track && !conn) held_q <= ~held_q;
      else if (track && differential_select) held_q <= 10'h200 + lvl[pos_sel*10 +: 10] - lvl[neg_sel*10 +: 10];
      else if (track) held_q <= lvl[pos_sel*10 +: 10];
    end
  end
  // Unpowered comparator chatters rather than give a clean level
  assign comp = pwr ? (held_q >= trial) : tog_q;
endmodule // dmc_front_model

// ---- bench/tb.sv ----
// Self-checking bench for the converter control block over APB.
// Assumes the block, its register header and the front-end model.
`timescale 1ns/1ps
`include "dmc_map.vh"
module tb;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, rd;
  logic [2:0] tmr = 3'h0;
  // Pin levels: channel 5 single-ended, channels 2 and 3 a pair
  logic [79:0] lvl = {20'h00000, 10'h0A3, 10'h000, 10'h210, 10'h250, 20'h00000};
  int failures = 0;
  int comparisons = 0;
  wire [31:0] prdata;
  wire [9:0] sar, dac_code;
  wire [2:0] pos_sel, neg_sel;
  wire pready, pslverr, comp, power_en, osc_on, mux_conn, mux_differential_select, track, pins_in, build, rel, busy, done;
  always #2 clk = ~clk;
  // --------------------
  // Block and partner
  // --------------------
  dmc_ctrl dmc_ctrl_inst (.CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TMR_OVF(tmr), .COMP_HI(comp),
    .POWER_EN(power_en), .OSC_FORCE_ON(osc_on), .MUX_CONNECT(mux_conn), .MUX_DIFFERENTIAL_SELECT(mux_differential_select),
    .MUX_POS_SEL(pos_sel), .MUX_NEG_SEL(neg_sel), .SAMPLE_TRACK(track), .SAR_CODE(sar),
    .DAC_PINS_INPUT_ONLY(pins_in), .DAC_CODE(dac_code), .DAC_BUILD(build), .DAC_RELEASE(rel), .BUSY(busy),
    .DONE_FLAG(done));
  dmc_front_model dmc_front_model_inst (.clk(clk), .rst_n(rst_n), .pwr(power_en), .conn(mux_conn),
    .differential_select(mux_differential_select), .pos_sel(pos_sel), .neg_sel(neg_sel), .track(track), .trial(sar), .lvl(lvl), .comp(comp));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up();
    if (failures == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic stop();
    failures++;
    wrap_up();
  endtask
  // Request held until the edge that samples the answer
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n == 20) stop();
    @(posedge clk);
  endtask
  function automatic logic [15:0] fmt(input logic [9:0] lv, input logic la);
    logic [9:0] r;
    r = lv ^ 10'h200;
    return la ? {r, 6'h00} : {{6{r[9]}}, r};
  endfunction
  task automatic res(input logic [15:0] x);
    apb(0, `DMC_OFF_RES_LO, 8'h00);
    chk("result low", {24'h0, x[7:0]}, rd);
    apb(0, `DMC_OFF_RES_HI, 8'h00);
    chk("result high", {24'h0, x[15:8]}, rd);
  endtask
  // Counts phase lengths; timer 0 overflows at the start and 50 cycles in
  task automatic run(input int eb, ebld, erel, est, elead);
    int nb = 0, nbld = 0, nrel = 0, nst = 0, fs = -1, i;
    for (i = 0; i < 2000 && !(nb > 0 && busy !== 1'b1); i++) begin
      @(posedge clk);
      tmr <= (i == 0 || i == 50) ? 3'h1 : 3'h0;
      if (track === 1'b1 && fs < 0) fs = nb;
      nb += (busy === 1'b1);
      nbld += (build === 1'b1);
      nrel += (rel === 1'b1);
      nst += (track === 1'b1);
    end
    if (i == 2000) stop();
    chk("busy", eb, nb);
    chk("build", ebld, nbld);
    chk("release", erel, nrel);
    chk("sample", est, nst);
    chk("sample lead", elead, fs);
  endtask
  // --------------------
  // Scenarios
  // --------------------
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(0, `DMC_OFF_CTRL, 8'h00);
    chk("ctrl reset", 32'h0, rd);
    apb(0, `DMC_OFF_INPUT, 8'h00);
    chk("input reset", 32'h0, rd);
    apb(0, 8'h10, 8'h00);
    chk("unmapped", 32'h1, {31'h0, e});
    // Channel 5, right aligned, tick every 8 core cycles
    apb(1, `DMC_OFF_INPUT, 8'h85);
    apb(1, `DMC_OFF_CTRL, 8'h53);
    run(104, 0, 0, 8, 16);
    chk("done flag", 32'h1, {31'h0, done});
    apb(0, `DMC_OFF_CTRL, 8'h00);
    chk("ctrl done", 32'h93, rd);
    res(fmt(10'h0A3, 1'b0));
    // Result writes must not land in ADC mode
    apb(1, `DMC_OFF_RES_LO, 8'h55);
    apb(1, `DMC_OFF_CTRL, 8'h93);
    apb(0, `DMC_OFF_CTRL, 8'h00);
    chk("ctrl cleared", 32'h13, rd);
    res(fmt(10'h0A3, 1'b0));
    // Pair 1, left aligned; connect dropped around the change
    apb(1, `DMC_OFF_INPUT, 8'h05);
    apb(1, `DMC_OFF_INPUT, 8'h09);
    apb(1, `DMC_OFF_INPUT, 8'h89);
    apb(1, `DMC_OFF_CTRL, 8'h5B);
    run(104, 0, 0, 8, 16);
    res(fmt(10'h240, 1'b1));
    // Timer 0 trigger; second overflow lands mid-conversion
    apb(1, `DMC_OFF_INPUT, 8'h99);
    apb(1, `DMC_OFF_CTRL, 8'h13);
    run(104, 0, 0, 8, 16);
    res(fmt(10'h240, 1'b0));
    // DAC with connect left set
    apb(1, `DMC_OFF_INPUT, 8'h89);
    apb(1, `DMC_OFF_CTRL, 8'h33);
    apb(1, `DMC_OFF_RES_LO, 8'h5A);
    apb(1, `DMC_OFF_RES_HI, 8'h02);
    apb(1, `DMC_OFF_CTRL, 8'h73);
    run(88, 80, 40, 0, -1);
    chk("dac code", 32'h25A, {22'h0, dac_code});
    chk("dac pins", 32'h2, {30'h0, pins_in, mux_conn});
    res(16'h0000);
    // Internal source: 125 core cycles per tick
    apb(1, `DMC_OFF_CTRL, 8'h50);
    run(1625, 0, 0, 125, 250);
    chk("osc power", 32'h3, {30'h0, osc_on, power_en});
    apb(1, `DMC_OFF_CTRL, 8'h00);
    @(posedge clk);
    chk("osc power off", 32'h0, {30'h0, osc_on, power_en});
    wrap_up();
  end
endmodule // tb
